/* dchp_byte_fifo.sv */
/*
 * Small byte FIFO with a registered output stage.
 * Assumes one clock, synchronous active-high reset, power-of-two DEPTH.
 */
`timescale 1ns/1ns
`default_nettype none

module dchp_byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// Filling side
	input wire logic inValid,
	input wire logic [WIDTH-1:0] inData,
	output logic inReady,
	// Draining side
	output logic outValid,
	output logic [WIDTH-1:0] outData,
	input wire logic outReady
);

	localparam int PTR_W = $clog2(DEPTH);
	localparam int CNT_W = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_q [DEPTH]; // Storage words
	logic [PTR_W-1:0] wrPtr_q; // Next slot to fill
	logic [PTR_W-1:0] rdPtr_q; // Oldest word
	logic [CNT_W-1:0] count_q; // Words held in storage
	logic outValid_q; // Output stage holds a word
	logic [WIDTH-1:0] outData_q; // Output stage word
	logic push; // Word accepted this cycle
	logic load; // Storage moves to output stage

	// Full storage refuses, so the source really stalls
	assign inReady = (count_q != CNT_W'(DEPTH));
	assign push = inValid && inReady;
	assign load = (count_q != '0) && (!outValid_q || outReady);
	assign outValid = outValid_q;
	assign outData = outData_q;

	// Storage write
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_q[wrPtr_q] <= inData;
		end
	end

	// Pointers wrap naturally at a power-of-two depth
	always_ff @(posedge core_clk) begin
		if (srst) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
		end else begin
			if (push) begin
				wrPtr_q <= wrPtr_q + 1'b1;
			end
			if (load) begin
				rdPtr_q <= rdPtr_q + 1'b1;
			end
		end
	end

	// Occupancy
	always_ff @(posedge core_clk) begin
		if (srst) begin
			count_q <= '0;
		end else if (push && !load) begin
			count_q <= count_q + 1'b1;
		end else if (!push && load) begin
			count_q <= count_q - 1'b1;
		end
	end

	// Registered output stage
	always_ff @(posedge core_clk) begin
		if (srst) begin
			outValid_q <= 1'b0;
			outData_q <= '0;
		end else if (load) begin
			outValid_q <= 1'b1;
			outData_q <= mem_q[rdPtr_q];
		end else if (outReady) begin
			outValid_q <= 1'b0;
		end
	end

endmodule

`default_nettype wire

/* dchp_cpu_model.sv */
/*
 * Processor bus model: drives the strobe pins, polls status.
 * Assumes the bench calls its tasks; pins change at falling edges.
 */
`timescale 1ns/1ns
`default_nettype none

module dchp_cpu_model (
	// Clock
	input wire logic core_clk,
	// Pins
	output logic csN,
	output logic rdN,
	output logic wrN,
	output logic registerSelect,
	output logic [7:0] dbIn,
	input wire logic [7:0] dbOut,
	input wire logic dbOeN
);
	// Idle pins at time zero
	initial begin
		csN = 1'b1;
		rdN = 1'b1;
		wrN = 1'b1;
		registerSelect = 1'b0;
		dbIn = 8'hA5;
	end

	// One strobe only, held 6 cycles, 6 cycles idle after
	task automatic access(input logic c, s, w, input logic [7:0] d,
		output logic [7:0] q, output logic oe);
		@(negedge core_clk);
		csN = c;
		registerSelect = s;
		dbIn = w ? d : ~dbIn;
		rdN = w;
		wrN = !w;
		repeat (6) @(negedge core_clk);
		q = dbOut;
		oe = dbOeN;
		rdN = 1'b1;
		wrN = 1'b1;
		csN = 1'b1;
		dbIn = ~dbIn; // Released bus flips, never holds
		repeat (6) @(negedge core_clk);
	endtask

	// Poll ready and direction together before a data access; last status returned
	task automatic waitReady(input logic dir, output logic ok, output logic [7:0] q);
		logic oe;
		ok = 1'b0;
		for (int i = 0; i < 20 && !ok; i++) begin
			access(1'b0, 1'b0, 1'b0, 8'h00, q, oe);
			ok = (q[7] === 1'b1) && (q[6] === dir);
		end
	endtask
endmodule

`default_nettype wire

/* dchp_host_port.sv */
/*
 * Processor-facing port of the disk controller: main status register,
 * stacked data register, phase tracking, interrupt and DMA handshake.
 * Assumes the processor pins are asynchronous to core_clk and that the
 * controller core beside it runs on core_clk and decodes commands.
 */
`timescale 1ns/1ns
`default_nettype none

module dchp_host_port (
	// Clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// Processor bus pins
	input wire logic csN,
	input wire logic rdN,
	input wire logic wrN,
	input wire logic registerSelect,
	input wire logic [7:0] dbIn,
	output logic [7:0] dbOut,
	output logic dbOeN,
	// Interrupt and DMA pins
	output logic intReq,
	output logic drq,
	input wire logic dackN,
	input wire logic terminalCount,
	// Core status inputs
	input wire logic [3:0] driveSeeking,
	input wire logic dmaMode,
	input wire logic execToHost,
	input wire logic cmdComplete,
	input wire logic execDone,
	input wire logic dmaRequest,
	// Inbound bytes toward the core
	output logic cmdValid,
	output logic [7:0] cmdByte,
	input wire logic cmdReady,
	output logic [3:0] cmdByteIndex,
	// Outbound bytes from the core
	input wire logic resValid,
	input wire logic [7:0] resByte,
	input wire logic resLast,
	output logic resReady,
	// Core notifications
	output logic dmaAck,
	output logic tcSeen,
	output logic [1:0] phase
);

	// ****************************************
	// Decode of one synchronised bus state
	// ****************************************

	// Illegal strobe pairs decode to no access at all
	function automatic dchp_pkg::dchp_acc_t decodeAccess(
		input logic cs_n,
		input logic rd_n,
		input logic wr_n,
		input logic sel
	);
		dchp_pkg::dchp_acc_t acc;
		acc = dchp_pkg::ACC_NONE;
		if (!cs_n) begin
			if (!rd_n && wr_n) begin
				acc = sel ? dchp_pkg::ACC_DATA_RD : dchp_pkg::ACC_STATUS_RD;
			end else if (rd_n && !wr_n && sel) begin
				acc = dchp_pkg::ACC_DATA_WR;
			end
		end
		return acc;
	endfunction

	// ****************************************
	// Declarations
	// ****************************************
	logic [13:0] pinS1_q; // First synchroniser stage
	logic [13:0] pinS2_q; // Second synchroniser stage
	dchp_pkg::dchp_acc_t acc; // Access this cycle
	dchp_pkg::dchp_acc_t accPrev_q; // Access last cycle
	logic [7:0] wrLatch_q; // Last byte seen during a write
	logic dackPrev_q; // Acknowledge last cycle
	logic writeEnd; // Data write just finished
	logic readEnd; // Data read just finished
	dchp_pkg::dchp_phase_t phase_q; // Current command phase
	logic pioExec; // Non-DMA execution in progress
	logic inboundOpen; // Processor may write bytes now
	logic outboundOpen; // Processor may read bytes now
	logic fifoInReady; // Inbound stack has room
	logic fifoPush; // Byte offered to the stack
	logic [7:0] resHold_q; // Byte presented for reading
	logic resFull_q; // Presented byte is valid
	logic resLastHold_q; // Presented byte closes the result
	logic resReady_q; // Core may hand over a byte
	logic resTake; // Core byte accepted
	logic [7:0] status_q; // Main status register
	logic readyNow; // Ready flag as it stands now
	logic [7:0] dbOut_q; // Data bus drive value
	logic dbOeN_q; // Data bus enable, low drives
	logic intReq_q; // Interrupt request
	logic drq_q; // DMA request pin
	logic dmaAck_q; // Acknowledge pulse to core
	logic tcSeen_q; // Terminal count level to core
	logic [3:0] cmdIndex_q; // Command byte counter

	// ****************************************
	// Pin synchronisers
	// ****************************************

	// Two flops on every pin; only stage two is looked at
	always_ff @(posedge core_clk) begin
		if (srst) begin
			pinS1_q <= dchp_pkg::PIN_RST;
			pinS2_q <= dchp_pkg::PIN_RST;
		end else begin
			pinS1_q <= {csN, rdN, wrN, registerSelect, dackN, terminalCount, dbIn};
			pinS2_q <= pinS1_q;
		end
	end

	// ****************************************
	// Host access tracking
	// ****************************************

	// Current decode from stage two
	assign acc = decodeAccess(pinS2_q[13], pinS2_q[12], pinS2_q[11], pinS2_q[10]);

	// Previous decode, for end-of-strobe detection
	always_ff @(posedge core_clk) begin
		if (srst) begin
			accPrev_q <= dchp_pkg::ACC_NONE;
		end else begin
			accPrev_q <= acc;
		end
	end

	// Bus data is settled by the end of the strobe, so keep the latest
	always_ff @(posedge core_clk) begin
		if (srst) begin
			wrLatch_q <= dchp_pkg::BYTE_RST;
		end else if (acc == dchp_pkg::ACC_DATA_WR) begin
			wrLatch_q <= pinS2_q[7:0];
		end
	end

	// Acting at the strobe's rising edge, a long strobe counts once
	assign writeEnd = (accPrev_q == dchp_pkg::ACC_DATA_WR) && (acc != dchp_pkg::ACC_DATA_WR);
	assign readEnd = (accPrev_q == dchp_pkg::ACC_DATA_RD) && (acc != dchp_pkg::ACC_DATA_RD);

	// ****************************************
	// Command phase sequencing
	// ****************************************

	// Phases always run command, execute, result, command
	always_ff @(posedge core_clk) begin
		if (srst) begin
			phase_q <= dchp_pkg::PH_COMMAND;
		end else begin
			case (phase_q)
				dchp_pkg::PH_COMMAND: begin
					if (cmdComplete) begin
						phase_q <= dchp_pkg::PH_EXECUTE;
					end
				end
				dchp_pkg::PH_EXECUTE: begin
					if (execDone) begin
						phase_q <= dchp_pkg::PH_RESULT;
					end
				end
				dchp_pkg::PH_RESULT: begin
					// Last result byte read returns to command intake
					if (readEnd && resFull_q && resLastHold_q) begin
						phase_q <= dchp_pkg::PH_COMMAND;
					end
				end
				default: begin
					phase_q <= dchp_pkg::PH_COMMAND;
				end
			endcase
		end
	end

	// Which way bytes move in the current phase
	assign pioExec = (phase_q == dchp_pkg::PH_EXECUTE) && !dmaMode;
	assign inboundOpen = (phase_q == dchp_pkg::PH_COMMAND) || (pioExec && !execToHost);
	assign outboundOpen = (phase_q == dchp_pkg::PH_RESULT) || (pioExec && execToHost);

	// ****************************************
	// Inbound byte stack
	// ****************************************

	// Writes outside an inbound phase, or into a full stack, are dropped
	assign fifoPush = writeEnd && inboundOpen;

	// Stacked data register toward the core
	dchp_byte_fifo #(
		.WIDTH(dchp_pkg::BYTE_W),
		.DEPTH(dchp_pkg::FIFO_DEPTH)
	) inboundStack (
		.core_clk(core_clk),
		.srst(srst),
		.inValid(fifoPush),
		.inData(wrLatch_q),
		.inReady(fifoInReady),
		.outValid(cmdValid),
		.outData(cmdByte),
		.outReady(cmdReady)
	);

	// Byte position within a command, for the core's opcode decode
	always_ff @(posedge core_clk) begin
		if (srst) begin
			cmdIndex_q <= dchp_pkg::INDEX_RST;
		end else if (phase_q != dchp_pkg::PH_COMMAND) begin
			cmdIndex_q <= dchp_pkg::INDEX_RST;
		end else if (fifoPush && fifoInReady && cmdIndex_q != dchp_pkg::INDEX_MAX) begin
			cmdIndex_q <= cmdIndex_q + 1'b1;
		end
	end

	// ****************************************
	// Outbound presented byte
	// ****************************************

	// Core hands a byte only while the slot is free
	assign resTake = resValid && resReady_q;

	// Ready is registered; it drops the cycle after a take
	always_ff @(posedge core_clk) begin
		if (srst) begin
			resReady_q <= 1'b0;
		end else begin
			resReady_q <= outboundOpen && !resFull_q && !resTake;
		end
	end

	// Presented byte: loaded by the core, freed by a processor read
	always_ff @(posedge core_clk) begin
		if (srst) begin
			resHold_q <= dchp_pkg::BYTE_RST;
			resFull_q <= 1'b0;
			resLastHold_q <= 1'b0;
		end else if (resTake) begin
			resHold_q <= resByte;
			resFull_q <= 1'b1;
			resLastHold_q <= resLast;
		end else if (readEnd && resFull_q) begin
			resFull_q <= 1'b0;
			resLastHold_q <= 1'b0;
		end
	end

	// ****************************************
	// Main status register
	// ****************************************

	// Ready follows the slot in use for the current direction
	assign readyNow = outboundOpen ? resFull_q : (inboundOpen && fifoInReady);

	// Rebuilt every cycle; nothing the processor does writes it
	always_ff @(posedge core_clk) begin
		if (srst) begin
			status_q <= dchp_pkg::STATUS_RST;
		end else begin
			status_q[dchp_pkg::ST_SEEK_LSB +: dchp_pkg::DRIVES] <= driveSeeking;
			status_q[dchp_pkg::ST_RSVD] <= 1'b0;
			status_q[dchp_pkg::ST_PIO] <= pioExec;
			status_q[dchp_pkg::ST_DIR] <= outboundOpen;
			status_q[dchp_pkg::ST_READY] <= readyNow;
		end
	end

	// ****************************************
	// Data bus drive
	// ****************************************

	// Status is served in every phase; the bus floats when not read
	always_ff @(posedge core_clk) begin
		if (srst) begin
			dbOut_q <= dchp_pkg::BYTE_RST;
			dbOeN_q <= 1'b1;
		end else begin
			case (acc)
				dchp_pkg::ACC_STATUS_RD: begin
					dbOut_q <= status_q;
					dbOeN_q <= 1'b0;
				end
				dchp_pkg::ACC_DATA_RD: begin
					dbOut_q <= resHold_q;
					dbOeN_q <= 1'b0;
				end
				default: begin
					dbOut_q <= dbOut_q;
					dbOeN_q <= 1'b1;
				end
			endcase
		end
	end

	// ****************************************
	// Interrupt request
	// ****************************************

	// Raised each time ready rises in non-DMA execution and at result entry;
	// a data access clears it, but a new cause in that cycle wins
	always_ff @(posedge core_clk) begin
		if (srst) begin
			intReq_q <= 1'b0;
		end else if (pioExec && readyNow && !status_q[dchp_pkg::ST_READY]) begin
			intReq_q <= 1'b1;
		end else if (execDone && phase_q == dchp_pkg::PH_EXECUTE) begin
			intReq_q <= 1'b1;
		end else if (readEnd || writeEnd) begin
			intReq_q <= 1'b0;
		end
	end

	// ****************************************
	// DMA handshake
	// ****************************************

	// Request only while executing in DMA mode
	always_ff @(posedge core_clk) begin
		if (srst) begin
			drq_q <= 1'b0;
		end else begin
			drq_q <= (phase_q == dchp_pkg::PH_EXECUTE) && dmaMode && dmaRequest;
		end
	end

	// Acknowledge start as a pulse, terminal count as a level
	always_ff @(posedge core_clk) begin
		if (srst) begin
			dackPrev_q <= 1'b1;
			dmaAck_q <= 1'b0;
			tcSeen_q <= 1'b0;
		end else begin
			dackPrev_q <= pinS2_q[9];
			dmaAck_q <= dackPrev_q && !pinS2_q[9];
			tcSeen_q <= pinS2_q[8];
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign dbOut = dbOut_q;
	assign dbOeN = dbOeN_q;
	assign intReq = intReq_q;
	assign drq = drq_q;
	assign resReady = resReady_q;
	assign cmdByteIndex = cmdIndex_q;
	assign dmaAck = dmaAck_q;
	assign tcSeen = tcSeen_q;
	assign phase = phase_q;

endmodule

`default_nettype wire

/* dchp_host_port_properties.sv */
/*
 * Checker for the host port pins and core handshakes.
 * Assumes one clock, core_clk, and sync active-high srst.
 */
`timescale 1ns/1ns
`default_nettype none

module dchp_host_port_checker (
	// Clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// Pins
	input wire logic csN,
	input wire logic rdN,
	input wire logic registerSelect,
	input wire logic [7:0] dbOut,
	input wire logic dbOeN,
	input wire logic intReq,
	input wire logic drq,
	// Core side
	input wire logic [3:0] driveSeeking,
	input wire logic dmaMode,
	input wire logic dmaRequest,
	input wire logic cmdValid,
	input wire logic [7:0] cmdByte,
	input wire logic cmdReady,
	input wire logic dmaAck,
	input wire logic [1:0] phase
);
	// ****
	// Helpers
	// ****
	logic [3:0] selH; // Recent select history
	logic statRd; // Status byte on the bus

	// Select history covers the sync and output lag
	always_ff @(posedge core_clk) begin
		selH <= {selH[2:0], registerSelect};
	end
	assign statRd = !dbOeN && selH == 4'h0 && !registerSelect;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	// ****
	// Assertions
	// ****
	a_cs_off_bus: assert property (csN && $past(csN) && $past(csN, 3) |-> dbOeN)
		else $error("bus driven without chip select");
	a_idle_no_drive: assert property (rdN && $past(rdN) && $past(rdN, 3) |-> dbOeN)
		else $error("bus driven without read strobe");
	a_bit4_zero: assert property (statRd |-> dbOut[4] == 1'b0)
		else $error("status bit 4 set");
	a_seek_bits: assert property (statRd && driveSeeking == $past(driveSeeking, 4)
		|-> dbOut[3:0] == driveSeeking)
		else $error("seek flags wrong");
	a_pio_only_exec: assert property (statRd && phase != 2'h1
		&& $past(phase, 3) != 2'h1 |-> !dbOut[5])
		else $error("execution flag outside execution");
	a_drq_cause: assert property ($rose(drq) |-> $past(phase) == 2'h1
		&& $past(dmaMode) && $past(dmaRequest))
		else $error("request without cause");
	a_ack_pulse: assert property (dmaAck |=> !dmaAck)
		else $error("acknowledge pulse too long");
	a_cmd_hold: assert property (cmdValid && !cmdReady |=> cmdValid && $stable(cmdByte))
		else $error("inbound byte lost");
	a_reset_state: assert property ($past(srst) |-> dbOeN && !intReq && !drq
		&& !cmdValid && phase == 2'h0)
		else $error("reset state wrong");
	// Idle acknowledge pin must not look like a falling edge after reset
	a_no_false_ack: assert property ($past(srst) |=> !dmaAck)
		else $error("acknowledge pulse after reset");

	// Main scenarios reached
	c_drq: cover property ($rose(drq));
	c_int: cover property ($rose(intReq));
	c_stat: cover property (statRd);
endmodule

bind dchp_host_port dchp_host_port_checker i_chk (.core_clk(core_clk), .srst(srst),
	.csN(csN), .rdN(rdN), .registerSelect(registerSelect), .dbOut(dbOut), .dbOeN(dbOeN),
	.intReq(intReq), .drq(drq), .driveSeeking(driveSeeking), .dmaMode(dmaMode),
	.dmaRequest(dmaRequest), .cmdValid(cmdValid), .cmdByte(cmdByte), .cmdReady(cmdReady),
	.dmaAck(dmaAck), .phase(phase));

`default_nettype wire

/* dchp_pkg.sv */
/*
 * Shared constants for the disk controller host port: status bit
 * positions, access codes, phase encoding, reset values and widths.
 * Assumes it is compiled before every other file of the block.
 */
package dchp_pkg;

	// ********************************
	// Widths
	// ********************************
	localparam int BYTE_W = 8; // Data bus width
	localparam int DRIVES = 4; // Drives with seek flags
	localparam int FIFO_DEPTH = 4; // Inbound stack depth
	localparam int INDEX_W = 4; // Command byte counter width
	localparam int PIN_W = 14; // Synchronised pin bundle width

	// ********************************
	// Status register bit positions
	// ********************************
	localparam int ST_SEEK_LSB = 0; // Drive seek flags, bits 3..0
	localparam int ST_RSVD = 4; // Undefined bit
	localparam int ST_PIO = 5; // pio_execution_flag
	localparam int ST_DIR = 6; // transfer_direction
	localparam int ST_READY = 7; // port_ready

	// ********************************
	// Reset values
	// ********************************
	localparam logic [7:0] STATUS_RST = 8'h00; // All flags clear, dir in
	localparam logic [7:0] BYTE_RST = 8'h00; // Empty byte
	localparam logic [3:0] INDEX_RST = 4'h0; // No command byte yet
	localparam logic [3:0] INDEX_MAX = 4'hF; // Counter saturates here
	localparam logic [13:0] PIN_RST = 14'h3EFF; // Pins idle: strobes, acknowledge high, count low

	// ********************************
	// Host access decode
	// ********************************
	typedef enum logic [1:0] {
		ACC_NONE = 2'b00,
		ACC_STATUS_RD = 2'b01,
		ACC_DATA_RD = 2'b10,
		ACC_DATA_WR = 2'b11
	} dchp_acc_t;

	// ********************************
	// Command phases
	// ********************************
	typedef enum logic [1:0] {
		PH_COMMAND = 2'b00,
		PH_EXECUTE = 2'b01,
		PH_RESULT = 2'b10
	} dchp_phase_t;

endpackage

/* disk_controller_host_port_bench.sv */
/*
 * Self-checking bench for the host port with a processor model.
 * Assumes the core side is played by the bench procedures.
 */
`timescale 1ns/1ns
`default_nettype none

module disk_controller_host_port_bench;
	logic core_clk = 1'b0; // 10 MHz
	logic srst = 1'b1;
	logic csN, rdN, wrN, registerSelect, dbOeN, intReq, drq, dmaAck, tcSeen;
	logic [7:0] dbIn, dbOut, cmdByte, resByte = 8'h00;
	logic dackN = 1'b1, terminalCount = 1'b0, dmaMode = 1'b0, execToHost = 1'b0;
	logic cmdComplete = 1'b0, execDone = 1'b0, dmaRequest = 1'b0, cmdReady = 1'b0;
	logic resValid = 1'b0, resLast = 1'b0, resReady, cmdValid, ok, oe;
	logic [3:0] driveSeeking = 4'h0, cmdByteIndex;
	logic [1:0] phase;
	logic [7:0] q;
	int errors = 0, checkCount = 0, cyc = 0;

	always #50 core_clk = ~core_clk;

	dchp_cpu_model i_cpu (.core_clk(core_clk), .csN(csN), .rdN(rdN), .wrN(wrN),
		.registerSelect(registerSelect), .dbIn(dbIn), .dbOut(dbOut), .dbOeN(dbOeN));
	dchp_host_port i_dut (.core_clk(core_clk), .srst(srst), .csN(csN), .rdN(rdN),
		.wrN(wrN), .registerSelect(registerSelect), .dbIn(dbIn), .dbOut(dbOut),
		.dbOeN(dbOeN), .intReq(intReq), .drq(drq), .dackN(dackN),
		.terminalCount(terminalCount), .driveSeeking(driveSeeking), .dmaMode(dmaMode),
		.execToHost(execToHost), .cmdComplete(cmdComplete), .execDone(execDone),
		.dmaRequest(dmaRequest), .cmdValid(cmdValid), .cmdByte(cmdByte),
		.cmdReady(cmdReady), .cmdByteIndex(cmdByteIndex), .resValid(resValid),
		.resByte(resByte), .resLast(resLast), .resReady(resReady), .dmaAck(dmaAck),
		.tcSeen(tcSeen), .phase(phase));

	// Compare and count
	task automatic chk(input string what, input logic [7:0] seen, exp);
		checkCount++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic rd(input logic s);
		i_cpu.access(1'b0, s, 1'b0, 8'h00, q, oe);
	endtask

	task automatic wr(input logic s, input logic [7:0] d);
		i_cpu.access(1'b0, s, 1'b1, d, q, oe);
	endtask

	// One-cycle core pulse
	task automatic pulse(input int which);
		@(negedge core_clk);
		if (which == 0) cmdComplete = 1'b1; else execDone = 1'b1;
		@(negedge core_clk);
		cmdComplete = 1'b0;
		execDone = 1'b0;
		repeat (3) @(negedge core_clk);
	endtask

	// Offer one outbound byte until taken
	task automatic offer(input logic [7:0] b, input logic last);
		int k;
		@(negedge core_clk);
		resByte = b;
		resLast = last;
		resValid = 1'b1;
		for (k = 0; k < 20 && resReady !== 1'b1; k++) @(negedge core_clk);
		@(negedge core_clk);
		resValid = 1'b0;
	endtask

	task automatic t_reset;
		rd(1'b0);
		chk("status", q, 8'h80);
		chk("oe", {7'h0, oe}, 8'h00);
		$display("test reset done");
	endtask

	// Fill the stack until refused, then drain in order
	task automatic t_fill;
		int k;
		for (int i = 0; i < 5; i++) begin
			i_cpu.waitReady(1'b0, ok, q);
			chk("ready", {7'h0, ok}, 8'h01);
			wr(1'b1, 8'h10 + 8'(i));
		end
		rd(1'b0);
		chk("full status", q, 8'h00);
		wr(1'b1, 8'h77);
		cmdReady = 1'b1;
		for (int i = 0; i < 5; i++) begin
			for (k = 0; k < 20 && cmdValid !== 1'b1; k++) @(negedge core_clk);
			chk("cmdByte", cmdByte, 8'h10 + 8'(i));
			@(negedge core_clk);
		end
		repeat (4) @(negedge core_clk);
		chk("drained", {7'h0, cmdValid}, 8'h00);
		chk("index", {4'h0, cmdByteIndex}, 8'h05);
		$display("test fill done");
	endtask

	task automatic t_seek;
		driveSeeking = 4'h9;
		rd(1'b0);
		chk("seek status", q, 8'h89);
		driveSeeking = 4'h0;
		$display("test seek done");
	endtask

	// Deselected read and write with select 0 do nothing
	task automatic t_refuse;
		i_cpu.access(1'b1, 1'b0, 1'b0, 8'h00, q, oe);
		chk("cs oe", {7'h0, oe}, 8'h01);
		wr(1'b0, 8'h5A);
		chk("bad write", {7'h0, cmdValid}, 8'h00);
		chk("bad index", {4'h0, cmdByteIndex}, 8'h05);
		rd(1'b0);
		chk("status", q, 8'h80);
		$display("test refuse done");
	endtask

	// Non-DMA execution to processor, then result
	task automatic t_pio;
		pulse(0);
		chk("phase", {6'h0, phase}, 8'h01);
		rd(1'b0);
		chk("exec in status", q, 8'hA0);
		execToHost = 1'b1;
		offer(8'hC3, 1'b0);
		chk("res held", {7'h0, resReady}, 8'h00);
		i_cpu.waitReady(1'b1, ok, q);
		chk("exec status", q, 8'hE0);
		chk("int", {7'h0, intReq}, 8'h01);
		rd(1'b1);
		chk("data", q, 8'hC3);
		chk("int clr", {7'h0, intReq}, 8'h00);
		chk("res free", {7'h0, resReady}, 8'h01);
		pulse(1);
		chk("phase", {6'h0, phase}, 8'h02);
		offer(8'h3C, 1'b1);
		rd(1'b0);
		chk("result status", q, 8'hC0);
		rd(1'b1);
		chk("result", q, 8'h3C);
		chk("phase", {6'h0, phase}, 8'h00);
		execToHost = 1'b0;
		$display("test pio done");
	endtask

	// DMA execution: request, acknowledge, terminal count
	task automatic t_dma;
		int n = 0;
		dmaMode = 1'b1;
		pulse(0);
		dmaRequest = 1'b1;
		repeat (3) @(negedge core_clk);
		chk("drq", {7'h0, drq}, 8'h01);
		rd(1'b0);
		chk("no pio flag", {7'h0, q[5]}, 8'h00);
		dackN = 1'b0;
		repeat (8) begin
			@(negedge core_clk);
			n += int'(dmaAck === 1'b1);
		end
		chk("ack pulses", 8'(n), 8'h01);
		dackN = 1'b1;
		terminalCount = 1'b1;
		repeat (4) @(negedge core_clk);
		chk("tc", {7'h0, tcSeen}, 8'h01);
		$display("test dma done");
	endtask

	task automatic wrapUp;
		$display("checks %0d mismatches %0d", checkCount, errors);
		if (errors == 0 && checkCount > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Hang guard
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			wrapUp();
		end
	end

	initial begin
		repeat (12) @(negedge core_clk);
		srst = 1'b0;
		repeat (2) @(negedge core_clk);
		t_reset();
		t_fill();
		t_seek();
		t_refuse();
		t_pio();
		t_dma();
		wrapUp();
	end
endmodule

`default_nettype wire
